//--- core/irc_ctrl.sv
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module irc_ctrl
  import irc_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int SD_CYCLES = SD_LONG_CYC,
  parameter int LIMIT_CYCLES = PULSE_LIM_CYC
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic shutdown_in,
  output logic txd,
  input wire logic rxd
);

  irc_state_t state;
  logic [17:0] cnt;
  logic mode_high;
  logic ready;
  logic pend_high;
  logic rx_prev;
  logic rx_edge;
  logic shut_req;
  // Two-entry transmit buffer of 1-bit symbols; each symbol is a bit time.
  logic [1:0] buf_q;
  logic [1:0] buf_cnt;
  logic [15:0] bit_len;
  logic [15:0] bit_cnt;
  logic tx_bit;
  logic tx_active;
  logic [17:0] high_cnt;
  logic wr, rd;
  logic buf_in_ready, buf_out_valid, buf_pop;
  logic push;
  // Last count before the cut, so txd never stands high past the limit.
  localparam logic [17:0] LIM_LAST = 18'(LIMIT_CYCLES - 1);

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign buf_in_ready = buf_cnt != 2'h2;
  assign buf_out_valid = buf_cnt != 2'h0;
  assign push = wr && wb_adr_i == REG_TXDATA && wb_sel_i[2] && buf_in_ready;
  // Data is only sent in the idle state so no symbol disturbs the latch.
  assign buf_pop = buf_out_valid & (state == IRC_IDLE) & ready & ~tx_active;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wb_dat_o <= 32'h0;
    else if (rd)
    begin
      unique case (wb_adr_i)
        REG_STATUS: wb_dat_o <= {26'h0, rx_edge, ~rxd, ~buf_in_ready, ready, mode_high,
                                 state != IRC_IDLE};
        REG_TXDATA: wb_dat_o <= {16'h0, bit_len};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // Receive edge flag; a new edge in the clearing cycle wins.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rx_prev <= 1'b1;
      rx_edge <= 1'b0;
    end
    else
    begin
      rx_prev <= rxd;
      if (rx_prev & ~rxd & ready & ~tx_active)
        rx_edge <= 1'b1;
      else if (rd && wb_adr_i == REG_RXDATA)
        rx_edge <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pend_high <= 1'b0;
      shut_req <= 1'b0;
      bit_len <= BIT_LEN_RST;
    end
    else if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0])
    begin
      pend_high <= wb_dat_i[CTRL_HIGH];
      shut_req <= wb_dat_i[CTRL_SHUT];
    end
    else if (wr && wb_adr_i == REG_TXDATA && wb_sel_i[1:0] == 2'b11)
      bit_len <= wb_dat_i[15:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      buf_q <= 2'b00;
      buf_cnt <= 2'd0;
    end
    else
    begin
      // Push at offset 0x8 bit 16 while not full; pop from entry 0.
      if (push && buf_pop)
        buf_q <= {1'b0, (buf_cnt == 2'h1) ? wb_dat_i[16] : buf_q[1]} | {wb_dat_i[16], 1'b0};
      else if (push)
        buf_q[buf_cnt[0]] <= wb_dat_i[16];
      else if (buf_pop)
        buf_q <= {1'b0, buf_q[1]};
      buf_cnt <= buf_cnt + 2'(push) - 2'(buf_pop);
    end
  end

  // Emitting a symbol; a high symbol drives txd high for bit_len cycles.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_active <= 1'b0;
      tx_bit <= 1'b0;
      bit_cnt <= 16'h0;
    end
    else if (buf_pop)
    begin
      tx_active <= 1'b1;
      tx_bit <= buf_q[0];
      bit_cnt <= bit_len;
    end
    else if (tx_active)
    begin
      if (bit_cnt <= 16'h1)
        tx_active <= 1'b0;
      bit_cnt <= bit_cnt - 16'h1;
    end
  end

  // The host also cuts txd at the device limit so the emitter never stalls on.
  // The count holds through the rest of a cut symbol, so txd does not rise again.
  always_ff @(posedge clk_sys)
  begin
    if (rst || buf_pop || (!txd && !tx_active))
      high_cnt <= 18'h0;
    else if (txd && high_cnt != LIM_LAST)
      high_cnt <= high_cnt + 18'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= IRC_IDLE;
      cnt <= 18'h0;
      mode_high <= 1'b0;
      ready <= 1'b0;
      shutdown_in <= 1'b0;
      txd <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 18'h1;
      unique case (state)
        IRC_IDLE:
        begin
          txd <= tx_active & tx_bit & (high_cnt != LIM_LAST);
          if (!ready && cnt >= 18'(STARTUP_CYCLES))
            ready <= 1'b1;
          if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0] && !tx_active)
          begin
            if (wb_dat_i[CTRL_GO] || wb_dat_i[CTRL_SHUT])
            begin
              shutdown_in <= 1'b1;
              txd <= 1'b0;
              ready <= 1'b0;
              cnt <= 18'h0;
              state <= wb_dat_i[CTRL_SHUT] ? IRC_SHUT : IRC_SDHI;
            end
          end
        end
        IRC_SHUT:
          if (!shut_req)
          begin
            txd <= mode_high;
            cnt <= 18'h0;
            state <= IRC_SETUP;
          end
        IRC_SDHI:
        begin
          txd <= pend_high;
          cnt <= 18'h0;
          state <= IRC_SETUP;
        end
        IRC_SETUP:
          // Long shutdown so no receive glitch follows.
          if (cnt >= 18'(SD_CYCLES) && cnt >= 18'(SETUP_CYC))
          begin
            shutdown_in <= 1'b0;
            mode_high <= txd;
            cnt <= 18'h0;
            state <= IRC_HOLD;
          end
        IRC_HOLD:
          if (cnt >= 18'(HOLD_CYC))
          begin
            txd <= 1'b0;
            cnt <= 18'h0;
            state <= IRC_WARM;
          end
        IRC_WARM:
        begin
          cnt <= 18'h0;
          state <= IRC_IDLE;
        end
        default:
          state <= IRC_IDLE;
      endcase
    end
  end

endmodule : irc_ctrl

//--- core/irc_pkg.sv
package irc_pkg;

  localparam int CLK_MHZ = 50;
  // Setup and hold around the latching edge of shutdown, in ns.
  localparam int SETUP_NS = 200;
  localparam int HOLD_NS = 200;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  // Shutdown high time: longer than 4 us avoids the spurious receive pulse.
  localparam int SD_LONG_US = 5;
  localparam int SD_LONG_CYC = SD_LONG_US * CLK_MHZ;
  // Receiver start-up after the sequence, in us.
  localparam int STARTUP_US = 250;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  // Spurious receive pulse bound, in us.
  localparam int GLITCH_US = 2;
  localparam int GLITCH_CYC = GLITCH_US * CLK_MHZ;
  // Emitter pulse limit, in us.
  localparam int PULSE_LIM_US = 150;
  localparam int PULSE_LIM_CYC = PULSE_LIM_US * CLK_MHZ;
  // Symbol length in cycles after reset.
  localparam logic [15:0] BIT_LEN_RST = 16'h0032;

  // Register offsets, byte addresses.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TXDATA = 4'h8;
  localparam logic [3:0] REG_RXDATA = 4'hc;
  // Control fields.
  localparam int CTRL_GO = 0;
  localparam int CTRL_HIGH = 1;
  localparam int CTRL_SHUT = 2;
  // Status fields.
  localparam int ST_BUSY = 0;
  localparam int ST_HIGH = 1;
  localparam int ST_READY = 2;
  localparam int ST_TXFULL = 3;
  localparam int ST_RXLOW = 4;
  localparam int ST_RXEDGE = 5;

  typedef enum logic [2:0] {
    IRC_IDLE = 3'b000,
    IRC_SDHI = 3'b001,
    IRC_SETUP = 3'b011,
    IRC_HOLD = 3'b010,
    IRC_WARM = 3'b110,
    IRC_SHUT = 3'b111
  } irc_state_t;

  typedef struct packed {
    logic shutdown_in;
    logic txd;
  } irc_pins_t;

endpackage : irc_pkg

//--- test/irc_dev_model.sv
`timescale 1ns/1ps
module irc_dev_model #(parameter int LIM_NS = 800)
(
  input wire logic shutdown_in,
  input wire logic txd,
  input wire logic light,
  output logic rxd,
  output logic ir_emitter,
  output logic mode_high
);
  logic lim = 1'b0;
  // Rates are not modelled and no stray pulse occurs.
  initial mode_high = 1'b0;
  // An unknown level at power up is not latched.
  always @(negedge shutdown_in)
    if (txd !== 1'bx)
      mode_high = txd;
  always @(posedge txd)
  begin
    lim = 1'b0;
    #(LIM_NS) lim = txd;
  end
  assign ir_emitter = !shutdown_in && txd && !lim;
  assign rxd = shutdown_in || (txd ? lim : !light);
endmodule : irc_dev_model

//--- test/irc_ctrl_props.sv
`timescale 1ns/1ps
module irc_ctrl_props
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic shutdown_in,
  input wire logic txd
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  unmapped_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 4'h2
    |=> wb_dat_o == 32'h0) else $error("unmapped data");
  reset_idle_a: assert property (disable iff (1'b0) rst |=> !wb_ack_o && !shutdown_in && !txd)
    else $error("reset state");
  setup_a: assert property ($fell(shutdown_in) |-> txd == $past(txd, 10))
    else $error("setup short");
  hold_a: assert property ($fell(shutdown_in) |=> $stable(txd) [*8] ##1 $stable(txd) [*2])
    else $error("hold short");
  release_a: assert property ($fell(shutdown_in) && txd |-> ##[1:12] !txd)
    else $error("txd held");
  sd_long_a: assert property ($rose(shutdown_in) |=> shutdown_in [*8])
    else $error("shutdown short");
endmodule : irc_ctrl_props
bind irc_ctrl irc_ctrl_props u_props (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .shutdown_in, .txd);

//--- test/irc_ctrl_tb_top.sv
`timescale 1ns/1ps
module irc_ctrl_tb_top import irc_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic lt = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd, q;
  logic ack, sd, txd, rxd, em, md, h;
  logic [15:0] len;
  int num_errors = 0;
  int num_checks = 0;
  always #10 clk_sys = ~clk_sys;
  irc_ctrl #(.STARTUP_CYCLES(50), .SD_CYCLES(20), .LIMIT_CYCLES(40)) dut (.clk_sys, .rst,
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .shutdown_in(sd), .txd, .rxd);
  irc_dev_model dev (.shutdown_in(sd), .txd, .light(lt), .rxd, .ir_emitter(em),
    .mode_high(md));
  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
  endtask : bus
  // Polls status until the sequence and the receiver warm-up are over.
  task automatic settle;
    repeat (40)
    begin
      bus(1'b0, REG_STATUS, 32'h0);
      if (q[ST_BUSY] === 1'b0 && q[ST_READY] === 1'b1)
        break;
    end
  endtask : settle
  task automatic conclude;
    $display("%0d checks %0d errors", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial
  begin
    #200000;
    num_errors++;
    conclude();
  end
  initial
  begin
    void'($urandom(34));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    chk(md, 1'b0);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    // The first pass asks for low mode while already low.
    for (int i = 0; i < 6; i++)
    begin
      h = (i == 2) || (i > 2 && $urandom % 2 == 1);
      bus(1'b1, REG_CTRL, {30'h0, h, 1'b1});
      settle();
      chk(q[ST_HIGH], h);
      chk(md, h);
      chk(q[ST_READY], 1'b1);
      len = 16'(8 + $urandom % 8);
      bus(1'b1, REG_TXDATA, {15'h0, 1'b1, len});
      for (int k = 0; k < 20 && txd !== 1'b1; k++)
        @(posedge clk_sys);
      chk({rxd, em}, 2'b01);
      bus(1'b0, REG_TXDATA, 32'h0);
      chk(q[15:0], len);
      repeat (30) @(posedge clk_sys);
      lt <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(q[ST_RXLOW], 1'b1);
      chk(q[ST_RXEDGE], 1'b1);
      lt <= 1'b0;
      bus(1'b0, REG_RXDATA, 32'h0);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(q[ST_RXEDGE], 1'b0);
    end
    // A symbol longer than the pulse limit must be cut after 40 cycles.
    len = 16'h003c;
    bus(1'b1, REG_TXDATA, {15'h0, 1'b1, len});
    for (int k = 0; k < 20 && txd !== 1'b1; k++)
      @(posedge clk_sys);
    repeat (35) @(posedge clk_sys);
    chk(txd, 1'b1);
    repeat (6) @(posedge clk_sys);
    chk({txd, em}, 2'b00);
    repeat (30) @(posedge clk_sys);
    bus(1'b1, REG_CTRL, 32'h4);
    repeat (4) @(posedge clk_sys);
    chk({sd, rxd, em}, 3'b110);
    bus(1'b1, REG_TXDATA, {15'h0, 1'b1, 16'h0008});
    bus(1'b1, REG_TXDATA, {15'h0, 1'b1, 16'h0008});
    bus(1'b0, REG_STATUS, 32'h0);
    chk({txd, q[ST_TXFULL]}, 2'b01);
    bus(1'b1, REG_CTRL, 32'h0);
    settle();
    chk(md, h);
    conclude();
  end
endmodule : irc_ctrl_tb_top
